// ==== cgf_gateway.sv ====
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module cgf_gateway #(
  parameter int         FIFO_DEPTH = 8,
  parameter logic [4:0] SH_OBJ     = 5'h01,
  parameter logic [4:0] GW_SRC_OBJ = 5'h02
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Node A receive events
  input  wire logic        a_rx_valid,
  input  wire logic        a_rx_remote,
  input  wire logic [4:0]  a_rx_obj,
  input  wire logic [28:0] a_rx_id,
  input  wire logic [3:0]  a_rx_dlc,
  input  wire logic [63:0] a_rx_data,
  input  wire logic        a_tx_done,
  // Node A transmit request
  output logic             a_tx_req,
  output logic      [4:0]  a_tx_obj,
  output logic             a_tx_remote,
  output logic      [28:0] a_tx_id,
  output logic      [3:0]  a_tx_dlc,
  output logic      [63:0] a_tx_data,
  // Node B receive events
  input  wire logic        b_rx_valid,
  input  wire logic        b_rx_remote,
  input  wire logic [4:0]  b_rx_obj,
  input  wire logic [28:0] b_rx_id,
  input  wire logic [3:0]  b_rx_dlc,
  input  wire logic [63:0] b_rx_data,
  input  wire logic        b_tx_done,
  // Node B transmit request
  output logic             b_tx_req,
  output logic      [4:0]  b_tx_obj,
  output logic             b_tx_remote,
  output logic      [28:0] b_tx_id,
  output logic      [3:0]  b_tx_dlc,
  output logic      [63:0] b_tx_data
);
  import cgf_pkg::*;
  localparam int IW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  typedef struct packed {
    logic [2:0]                  sh_mode;
    logic                        sh_node;
    logic                        sh_dir;
    logic                        sh_auto;
    logic                        sh_fwd;
    logic                        sh_rx_irq_enable;
    logic                        sh_txie;
    logic [4:0]                  sh_ptr;
    logic [1:0]                  sh_transmit_request;
    logic [1:0]                  sh_rmt;
    logic [1:0]                  sh_new;
    logic [1:0]                  sh_irq;
    logic [1:0]                  sh_lost;
    logic [28:0]                 sh_id;
    logic [3:0]                  sh_dlc;
    logic [63:0]                 sh_data;
    logic [2:0]                  gw_mode;
    logic                        gw_node;
    logic                        gw_auto;
    logic [4:0]                  gw_ptr;
    logic [4:0]                  gw_flen;
    logic [2:0]                  ff_mode;
    logic                        ff_fwd;
    logic [1:0]                  ff_lock;
    logic [FIFO_DEPTH-1:0]       ff_transmit_request;
    logic [IW-1:0]               ff_sel;
    logic [FIFO_DEPTH-1:0][63:0] ff_data;
    logic [FIFO_DEPTH-1:0][3:0]  ff_dlc;
    logic [31:0]                 rdata;
    logic [1:0]                  tx_req;
    logic [1:0][4:0]             tx_obj;
    logic [1:0]                  tx_rmt;
    logic [1:0][28:0]            tx_id;
    logic [1:0][3:0]             tx_dlc;
    logic [1:0][63:0]            tx_data;
  } cgf_state_s;
  cgf_state_s state_reg;
  cgf_state_s state_next;
  // Two-bit set/reset field: 10 sets, 01 resets, others keep
  function automatic logic [1:0] upd2(input logic [1:0] cur, input logic [1:0] code);
    upd2 = (code == FLD_SET) ? FLD_SET : ((code == FLD_RST) ? FLD_RST : cur);
  endfunction
  // Element index inside the aligned power-of-two buffer
  function automatic logic [IW-1:0] elem_idx(input logic [4:0] obj, input logic [4:0] flen);
    logic [4:0] off;
    off = obj & flen;
    elem_idx = off[IW-1:0];
  endfunction
  // True when obj lies in the buffer whose base is aligned to flen+1
  function automatic logic in_fifo(input logic [4:0] obj, input logic [4:0] ptr,
                                   input logic [4:0] flen);
    in_fifo = ((obj & ~flen) == (ptr & ~flen));
  endfunction
  logic [1:0]       rx_valid;
  logic [1:0]       rx_remote;
  logic [1:0][4:0]  rx_obj;
  logic [1:0][28:0] rx_id;
  logic [1:0][3:0]  rx_dlc;
  logic [1:0][63:0] rx_data;
  logic [1:0]       tx_done;
  assign rx_valid  = {b_rx_valid, a_rx_valid};
  assign rx_remote = {b_rx_remote, a_rx_remote};
  assign rx_obj    = {b_rx_obj, a_rx_obj};
  assign rx_id     = {b_rx_id, a_rx_id};
  assign rx_dlc    = {b_rx_dlc, a_rx_dlc};
  assign rx_data   = {b_rx_data, a_rx_data};
  assign tx_done   = {b_tx_done, a_tx_done};
  always_comb begin
    cgf_state_s n;
    logic        sh_on;
    logic        ff_on;
    logic        dst;
    logic [IW-1:0] ix;
    logic [4:0]  base;
    logic        found;
    n = state_reg;
    sh_on = (state_reg.sh_mode == MODE_SHARED);
    ff_on = (state_reg.gw_mode == MODE_NORMAL) && (state_reg.ff_mode[2:1] == MODE_FIFO_HI);
    dst = ~state_reg.gw_node;
    base = state_reg.gw_ptr & ~state_reg.gw_flen;
    ix = '0;
    found = 1'b0;

    // Software access first, so hardware events below win
    n.rdata = RDATA_IDLE;
    if (reg_wr) begin
      unique case (reg_addr)
        SH_CFG_OFS: begin
          n.sh_mode = reg_wdata[MODE_LSB +: 3];
          n.sh_node = reg_wdata[NODE_BIT];
          n.sh_dir  = reg_wdata[DIR_BIT];
          n.sh_auto = reg_wdata[AUTO_BIT];
          n.sh_fwd  = reg_wdata[FWD_BIT];
          n.sh_rx_irq_enable = reg_wdata[RX_IRQ_ENABLE_BIT];
          n.sh_txie = reg_wdata[TXIE_BIT];
          n.sh_ptr  = reg_wdata[PTR_LSB +: 5];
        end
        SH_STAT_OFS: begin
          n.sh_transmit_request = upd2(state_reg.sh_transmit_request, reg_wdata[TRANSMIT_REQUEST_LSB +: 2]);
          n.sh_rmt  = upd2(state_reg.sh_rmt, reg_wdata[RMT_LSB +: 2]);
          n.sh_new  = upd2(state_reg.sh_new, reg_wdata[NEW_LSB +: 2]);
          n.sh_irq  = upd2(state_reg.sh_irq, reg_wdata[IRQ_LSB +: 2]);
          n.sh_lost = upd2(state_reg.sh_lost, reg_wdata[LOST_LSB +: 2]);
        end
        SH_ID_OFS:  n.sh_id = reg_wdata[28:0];
        SH_DLC_OFS: n.sh_dlc = reg_wdata[3:0];
        SH_DLO_OFS: n.sh_data[31:0] = reg_wdata;
        SH_DHI_OFS: n.sh_data[63:32] = reg_wdata;
        GW_CFG_OFS: begin
          n.gw_mode = reg_wdata[MODE_LSB +: 3];
          n.gw_node = reg_wdata[NODE_BIT];
          n.gw_auto = reg_wdata[AUTO_BIT];
          n.gw_ptr  = reg_wdata[PTR_LSB +: 5];
          n.gw_flen = reg_wdata[FLEN_LSB +: 5];
        end
        FIFO_CFG_OFS: begin
          n.ff_mode = reg_wdata[MODE_LSB +: 3];
          n.ff_fwd  = reg_wdata[FWD_BIT];
          n.ff_lock = upd2(state_reg.ff_lock, reg_wdata[LOCK_LSB +: 2]);
        end
        FIFO_TRANSMIT_REQUEST_OFS: n.ff_transmit_request = state_reg.ff_transmit_request | reg_wdata[FIFO_DEPTH-1:0];
        FIFO_SEL_OFS:  n.ff_sel = reg_wdata[IW-1:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        SH_CFG_OFS: begin
          n.rdata[MODE_LSB +: 3] = state_reg.sh_mode;
          n.rdata[NODE_BIT]      = state_reg.sh_node;
          n.rdata[DIR_BIT]       = state_reg.sh_dir;
          n.rdata[AUTO_BIT]      = state_reg.sh_auto;
          n.rdata[FWD_BIT]       = state_reg.sh_fwd;
          n.rdata[RX_IRQ_ENABLE_BIT]      = state_reg.sh_rx_irq_enable;
          n.rdata[TXIE_BIT]      = state_reg.sh_txie;
          n.rdata[PTR_LSB +: 5]  = state_reg.sh_ptr;
        end
        SH_STAT_OFS: begin
          n.rdata[TRANSMIT_REQUEST_LSB +: 2] = state_reg.sh_transmit_request;
          n.rdata[RMT_LSB +: 2]  = state_reg.sh_rmt;
          n.rdata[NEW_LSB +: 2]  = state_reg.sh_new;
          n.rdata[IRQ_LSB +: 2]  = state_reg.sh_irq;
          n.rdata[LOST_LSB +: 2] = state_reg.sh_lost;
        end
        SH_ID_OFS:  n.rdata[28:0] = state_reg.sh_id;
        SH_DLC_OFS: n.rdata[3:0] = state_reg.sh_dlc;
        SH_DLO_OFS: n.rdata = state_reg.sh_data[31:0];
        SH_DHI_OFS: n.rdata = state_reg.sh_data[63:32];
        GW_CFG_OFS: begin
          n.rdata[MODE_LSB +: 3] = state_reg.gw_mode;
          n.rdata[NODE_BIT]      = state_reg.gw_node;
          n.rdata[AUTO_BIT]      = state_reg.gw_auto;
          n.rdata[PTR_LSB +: 5]  = state_reg.gw_ptr;
          n.rdata[FLEN_LSB +: 5] = state_reg.gw_flen;
        end
        FIFO_CFG_OFS: begin
          n.rdata[MODE_LSB +: 3] = state_reg.ff_mode;
          n.rdata[FWD_BIT]       = state_reg.ff_fwd;
          n.rdata[LOCK_LSB +: 2] = state_reg.ff_lock;
        end
        FIFO_TRANSMIT_REQUEST_OFS: n.rdata[FIFO_DEPTH-1:0] = state_reg.ff_transmit_request;
        FIFO_SEL_OFS:  n.rdata[IW-1:0] = state_reg.ff_sel;
        FIFO_DLO_OFS:  n.rdata = state_reg.ff_data[state_reg.ff_sel][31:0];
        FIFO_DHI_OFS:  n.rdata = state_reg.ff_data[state_reg.ff_sel][63:32];
        FIFO_DLC_OFS:  n.rdata[3:0] = state_reg.ff_dlc[state_reg.ff_sel];
        default: ;
      endcase
    end

    // Shared object only hears the node it is assigned to now
    if (sh_on && rx_valid[state_reg.sh_node]
        && rx_obj[state_reg.sh_node] == SH_OBJ) begin
      if (!rx_remote[state_reg.sh_node] && !state_reg.sh_dir) begin
        if (state_reg.sh_new == FLD_SET) begin
          n.sh_lost = FLD_SET;
        end
        n.sh_node = ~state_reg.sh_node;
        n.sh_dir  = 1'b1;
        n.sh_id   = rx_id[state_reg.sh_node];
        n.sh_dlc  = rx_dlc[state_reg.sh_node];
        n.sh_data = rx_data[state_reg.sh_node];
        n.sh_new  = FLD_SET;
        n.sh_rmt  = FLD_RST;
        n.sh_transmit_request = state_reg.sh_auto ? FLD_SET : FLD_RST;
        if (state_reg.sh_rx_irq_enable) begin
          n.sh_irq = FLD_SET;
        end
      end else if (rx_remote[state_reg.sh_node] && state_reg.sh_dir) begin
        n.sh_transmit_request = FLD_SET;
        n.sh_rmt  = FLD_SET;
        if (state_reg.sh_fwd) begin
          n.sh_node = ~state_reg.sh_node;
          n.sh_dir  = 1'b0;
        end
        if (state_reg.sh_rx_irq_enable) begin
          n.sh_irq = FLD_SET;
        end
      end
    end
    if (sh_on && tx_done[state_reg.sh_node] && state_reg.tx_req[state_reg.sh_node]
        && state_reg.tx_obj[state_reg.sh_node] == SH_OBJ) begin
      n.sh_transmit_request = FLD_RST;
      n.sh_rmt  = FLD_RST;
      if (state_reg.sh_dir) begin
        n.sh_new = FLD_RST;
        if (!state_reg.sh_fwd) begin
          n.sh_node = ~state_reg.sh_node;
          n.sh_dir  = 1'b0;
        end
      end
      if (state_reg.sh_txie) begin
        n.sh_irq = FLD_SET;
      end
    end

    // Normal gateway: source copies into the element the pointer names
    if (ff_on && rx_valid[state_reg.gw_node] && !rx_remote[state_reg.gw_node]
        && rx_obj[state_reg.gw_node] == GW_SRC_OBJ) begin
      ix = elem_idx(state_reg.gw_ptr, state_reg.gw_flen);
      n.ff_data[ix] = rx_data[state_reg.gw_node];
      n.ff_dlc[ix]  = rx_dlc[state_reg.gw_node];
      if (state_reg.gw_auto) begin
        n.ff_transmit_request[ix] = 1'b1;
      end
      n.gw_ptr = base | ((state_reg.gw_ptr + 5'h01) & state_reg.gw_flen);
    end
    // Remote frames on a FIFO element are answered there, never forwarded
    if (ff_on && rx_valid[dst] && rx_remote[dst]
        && in_fifo(rx_obj[dst], state_reg.gw_ptr, state_reg.gw_flen)) begin
      n.ff_transmit_request[elem_idx(rx_obj[dst], state_reg.gw_flen)] = 1'b1;
    end
    if (ff_on && tx_done[dst] && state_reg.tx_req[dst] && state_reg.tx_obj[dst] != SH_OBJ) begin
      n.ff_transmit_request[elem_idx(state_reg.tx_obj[dst], state_reg.gw_flen)] = 1'b0;
    end

    // Transmit requests from next state, so a finished frame drops at once
    for (int x = 0; x < 2; x++) begin
      n.tx_req[x] = 1'b0;
      if (sh_on && n.sh_node == x[0] && n.sh_transmit_request == FLD_SET
          && !(n.sh_dir && n.sh_lost == FLD_SET)) begin
        n.tx_req[x]  = 1'b1;
        n.tx_obj[x]  = SH_OBJ;
        n.tx_rmt[x]  = ~n.sh_dir;
        n.tx_id[x]   = n.sh_id;
        n.tx_dlc[x]  = n.sh_dlc;
        n.tx_data[x] = n.sh_data;
      end else if (ff_on && dst == x[0] && n.ff_lock != FLD_SET) begin
        for (int e = FIFO_DEPTH - 1; e >= 0; e--) begin
          if (n.ff_transmit_request[e] && e <= int'(state_reg.gw_flen)) begin
            found = 1'b1;
            ix = IW'(e);
          end
        end
        if (found) begin
          n.tx_req[x]  = 1'b1;
          n.tx_obj[x]  = base | 5'(ix);
          n.tx_rmt[x]  = 1'b0;
          n.tx_id[x]   = ID_RESET;
          n.tx_dlc[x]  = n.ff_dlc[ix];
          n.tx_data[x] = n.ff_data[ix];
        end
      end
    end
    state_next = n;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg         <= '0;
      state_reg.sh_transmit_request <= FLD_RESET;
      state_reg.sh_rmt  <= FLD_RESET;
      state_reg.sh_new  <= FLD_RESET;
      state_reg.sh_irq  <= FLD_RESET;
      state_reg.sh_lost <= FLD_RESET;
      state_reg.ff_lock <= FLD_RESET;
      state_reg.sh_ptr  <= PTR_RESET;
      state_reg.gw_ptr  <= PTR_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata   = state_reg.rdata;
  assign a_tx_req    = state_reg.tx_req[0];
  assign a_tx_obj    = state_reg.tx_obj[0];
  assign a_tx_remote = state_reg.tx_rmt[0];
  assign a_tx_id     = state_reg.tx_id[0];
  assign a_tx_dlc    = state_reg.tx_dlc[0];
  assign a_tx_data   = state_reg.tx_data[0];
  assign b_tx_req    = state_reg.tx_req[1];
  assign b_tx_obj    = state_reg.tx_obj[1];
  assign b_tx_remote = state_reg.tx_rmt[1];
  assign b_tx_id     = state_reg.tx_id[1];
  assign b_tx_dlc    = state_reg.tx_dlc[1];
  assign b_tx_data   = state_reg.tx_data[1];
endmodule // cgf_gateway

// ==== cgf_pkg.sv ====
package cgf_pkg;
  // Register word offsets on the plain register port
  localparam logic [7:0] SH_CFG_OFS    = 8'h00;
  localparam logic [7:0] SH_STAT_OFS   = 8'h04;
  localparam logic [7:0] SH_ID_OFS     = 8'h08;
  localparam logic [7:0] SH_DLC_OFS    = 8'h0C;
  localparam logic [7:0] SH_DLO_OFS    = 8'h10;
  localparam logic [7:0] SH_DHI_OFS    = 8'h14;
  localparam logic [7:0] GW_CFG_OFS    = 8'h20;
  localparam logic [7:0] FIFO_CFG_OFS  = 8'h24;
  localparam logic [7:0] FIFO_TRANSMIT_REQUEST_OFS = 8'h28;
  localparam logic [7:0] FIFO_SEL_OFS  = 8'h2C;
  localparam logic [7:0] FIFO_DLO_OFS  = 8'h30;
  localparam logic [7:0] FIFO_DHI_OFS  = 8'h34;
  localparam logic [7:0] FIFO_DLC_OFS  = 8'h38;
  // Field positions, shared object, gateway source and FIFO config
  localparam int MODE_LSB  = 0;
  localparam int NODE_BIT  = 3;
  localparam int DIR_BIT   = 4;
  localparam int AUTO_BIT  = 5;
  localparam int FWD_BIT   = 6;
  localparam int RX_IRQ_ENABLE_BIT  = 7;
  localparam int TXIE_BIT  = 8;
  localparam int LOCK_LSB  = 9;
  localparam int PTR_LSB   = 16;
  localparam int FLEN_LSB  = 24;
  // Field positions, shared object status (two-bit set/reset codes)
  localparam int TRANSMIT_REQUEST_LSB  = 0;
  localparam int RMT_LSB   = 2;
  localparam int NEW_LSB   = 4;
  localparam int IRQ_LSB   = 6;
  localparam int LOST_LSB  = 8;
  // Encodings
  localparam logic [2:0] MODE_STD     = 3'h0;
  localparam logic [2:0] MODE_NORMAL  = 3'h4;
  localparam logic [2:0] MODE_SHARED  = 3'h5;
  localparam logic [1:0] MODE_FIFO_HI = 2'h1;
  localparam logic [1:0] FLD_SET      = 2'h2;
  localparam logic [1:0] FLD_RST      = 2'h1;
  // Reset values
  localparam logic [1:0]  FLD_RESET   = 2'h1;
  localparam logic [4:0]  PTR_RESET   = 5'h00;
  localparam logic [28:0] ID_RESET    = 29'h00000000;
  localparam logic [3:0]  DLC_RESET   = 4'h0;
  localparam logic [63:0] DATA_RESET  = 64'h0000000000000000;
  localparam logic [31:0] RDATA_IDLE  = 32'h00000000;
endpackage

// ==== cgf_gateway_monitor.sv ====
`timescale 1ns/1ps
module cgf_gateway_monitor #(
  parameter int         FIFO_DEPTH = 8,
  parameter logic [4:0] SH_OBJ     = 5'h01
) (
  // Clock, reset, write strobe
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        reg_wr,
  // Node A
  input wire logic        a_rx_valid,
  input wire logic        a_rx_remote,
  input wire logic [4:0]  a_rx_obj,
  input wire logic [63:0] a_rx_data,
  input wire logic        a_tx_done,
  input wire logic        a_tx_req,
  input wire logic [4:0]  a_tx_obj,
  input wire logic        a_tx_remote,
  // Node B
  input wire logic        b_rx_valid,
  input wire logic        b_rx_remote,
  input wire logic [4:0]  b_rx_obj,
  input wire logic        b_tx_done,
  input wire logic        b_tx_req,
  input wire logic [4:0]  b_tx_obj,
  input wire logic        b_tx_remote,
  input wire logic [63:0] b_tx_data
);
  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic quiet;
  // No event that may legally move a request
  assign quiet = !reg_wr && !a_rx_valid && !b_rx_valid && !a_tx_done && !b_tx_done;

  chk_b_tx_hold:
    assert property (b_tx_req && quiet |=> b_tx_req && $stable(b_tx_obj) && $stable(b_tx_data))
      else $error("B request moved");
  chk_a_tx_hold:
    assert property (a_tx_req && quiet |=> a_tx_req && $stable(a_tx_obj))
      else $error("A request moved");
  chk_b_done_drop:
    assert property (b_tx_req && b_tx_done |=> !b_tx_req || b_tx_obj != $past(b_tx_obj))
      else $error("B request kept after done");
  chk_a_done_drop:
    assert property (a_tx_req && a_tx_done |-> ##1 !a_tx_req)
      else $error("A request kept after done");
  chk_rise_cause:
    assert property ($rose(b_tx_req) |-> !$past(quiet) || !$past(quiet, 2))
      else $error("B request without cause");
  chk_fwd_data:
    assert property (a_rx_valid && !a_rx_remote && a_rx_obj == SH_OBJ && !b_tx_req
      ##1 b_tx_req && b_tx_obj == SH_OBJ |-> !b_tx_remote && b_tx_data == $past(a_rx_data))
      else $error("Forwarded data wrong");
  chk_fwd_remote:
    assert property (b_rx_valid && b_rx_remote && b_rx_obj == SH_OBJ ##1 $rose(a_tx_req)
      |-> a_tx_remote && a_tx_obj == SH_OBJ)
      else $error("Forwarded remote wrong");
  chk_rmt_answer:
    assert property (b_rx_valid && b_rx_remote && b_rx_obj == SH_OBJ && !b_tx_req
      ##1 $rose(b_tx_req) |-> !b_tx_remote && b_tx_obj == SH_OBJ)
      else $error("Remote answer wrong");

  cov_fwd: cover property (b_tx_req && b_tx_done && b_tx_obj == SH_OBJ);
  cov_rmt: cover property (a_tx_req && a_tx_done && a_tx_remote);
  cov_fifo: cover property (b_tx_req && b_tx_done && b_tx_obj != SH_OBJ);
endmodule // cgf_gateway_monitor

bind cgf_gateway cgf_gateway_monitor #(.FIFO_DEPTH(FIFO_DEPTH), .SH_OBJ(SH_OBJ)) mon_u (.*);

// ==== cgf_node_model.sv ====
`timescale 1ns/1ps
module cgf_node_model (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  // Frame asked of this node
  input  wire logic         tx_req,
  input  wire logic [102:0] tx_frm,
  output logic              tx_done,
  // Frames seen on the bus
  output logic              rx_valid,
  output logic      [102:0] rx_frm
);
  int           dly = 2;
  int           cnt;
  logic [102:0] sent[$];

  initial rx_valid = 1'b0;
  initial rx_frm = '0;

  // Bus time is a plain count; dly makes a slow node
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_done <= 1'b0;
      cnt     <= 0;
    end else if (tx_done || !tx_req) begin
      if (tx_done) begin
        sent.push_back(tx_frm[102] ? {tx_frm[102:64], 64'h0} : tx_frm);
      end
      tx_done <= 1'b0;
      cnt     <= 0;
    end else if (cnt >= dly) begin
      tx_done <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end

  task automatic send(input logic [102:0] f);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_frm   <= f;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    // Inverted copy, so a stale frame never looks live
    rx_frm   <= ~f;
  endtask
endmodule // cgf_node_model

// ==== can_gateway_fifo_and_shared_tb_top.sv ====
`timescale 1ns/1ps
module can_gateway_fifo_and_shared_tb_top;
  import cgf_pkg::*;
  localparam logic [4:0] SH    = 5'h01;
  localparam logic [4:0] SRC   = 5'h02;
  localparam int         LIMIT = 20000;
  logic         core_clk = 1'b0;
  logic         rst_b = 1'b0;
  logic [7:0]   reg_addr = 8'h00;
  logic [31:0]  reg_wdata = 32'h00000000;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [31:0]  reg_rdata;
  logic         a_rx_valid, a_rx_remote, a_tx_done, a_tx_req, a_tx_remote;
  logic         b_rx_valid, b_rx_remote, b_tx_done, b_tx_req, b_tx_remote;
  logic [4:0]   a_rx_obj, a_tx_obj, b_rx_obj, b_tx_obj;
  logic [28:0]  a_rx_id, a_tx_id, b_rx_id, b_tx_id, fid;
  logic [3:0]   a_rx_dlc, a_tx_dlc, b_rx_dlc, b_tx_dlc, fdlc;
  logic [63:0]  a_rx_data, a_tx_data, b_rx_data, b_tx_data, fd;
  logic [102:0] a_frm, b_frm, exp_a[$], exp_b[$];
  int           seed = 32'h026A;
  int           err_count = 0;
  int           n_tests = 0;
  int           cycles = 0;

  always #50 core_clk = ~core_clk;
  assign {a_rx_remote, a_rx_obj, a_rx_id, a_rx_dlc, a_rx_data} = a_frm;
  assign {b_rx_remote, b_rx_obj, b_rx_id, b_rx_dlc, b_rx_data} = b_frm;

  cgf_gateway #(.FIFO_DEPTH(4), .SH_OBJ(SH), .GW_SRC_OBJ(SRC)) dut_u (.*);
  cgf_node_model node_a (.core_clk(core_clk), .rst_b(rst_b), .tx_req(a_tx_req),
    .tx_frm({a_tx_remote, a_tx_obj, a_tx_id, a_tx_dlc, a_tx_data}), .tx_done(a_tx_done),
    .rx_valid(a_rx_valid), .rx_frm(a_frm));
  cgf_node_model node_b (.core_clk(core_clk), .rst_b(rst_b), .tx_req(b_tx_req),
    .tx_frm({b_tx_remote, b_tx_obj, b_tx_id, b_tx_dlc, b_tx_data}), .tx_done(b_tx_done),
    .rx_valid(b_rx_valid), .rx_frm(b_frm));

  function automatic logic [102:0] frm(input logic r, input logic [4:0] o,
                                       input logic [28:0] i, input logic [3:0] l,
                                       input logic [63:0] d);
    return {r, o, i, l, r ? 64'h0 : d};
  endfunction

  task automatic check(input logic [102:0] got, input logic [102:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(negedge core_clk);
    check(103'(reg_rdata), 103'(e));
  endtask

  task automatic rnd();
    fid  = 29'($random(seed));
    fdlc = 4'($random(seed));
    fd   = {32'($random(seed)), 32'($random(seed))};
  endtask

  // Length code of buffer elements is copied from the source frame, so masked
  task automatic settle(input logic m);
    logic [102:0] k;
    k = m ? ~(103'hF << 64) : ~103'h0;
    for (int i = 0; i < 400; i++) begin
      if (node_a.sent.size() == exp_a.size() && node_b.sent.size() == exp_b.size()) break;
      @(posedge core_clk);
    end
    repeat (30) @(posedge core_clk);
    check(103'(node_a.sent.size()), 103'(exp_a.size()));
    check(103'(node_b.sent.size()), 103'(exp_b.size()));
    while (exp_a.size() > 0 && node_a.sent.size() > 0)
      check(node_a.sent.pop_front() & k, exp_a.pop_front() & k);
    while (exp_b.size() > 0 && node_b.sent.size() > 0)
      check(node_b.sent.pop_front() & k, exp_b.pop_front() & k);
    exp_a.delete();
    exp_b.delete();
    node_a.sent.delete();
    node_b.sent.delete();
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(SH_STAT_OFS, 32'h00000155);
    rd(8'h3C, 32'h00000000);
    wr(SH_CFG_OFS, 32'h000100A5);
    for (int i = 0; i < 3; i++) begin
      rnd();
      node_a.send(frm(1'b0, SH, fid, fdlc, fd));
      exp_b.push_back(frm(1'b0, SH, fid, fdlc, fd));
      settle(1'b0);
      rd(SH_STAT_OFS, 32'h00000195);
    end
    rd(SH_CFG_OFS, 32'h000100A5);
    // Slow destination so a second source frame lands mid-transfer
    node_b.dly = 20;
    rnd();
    node_a.send(frm(1'b0, SH, fid, fdlc, fd));
    exp_b.push_back(frm(1'b0, SH, fid, fdlc, fd));
    node_a.send(frm(1'b0, SH, ~fid, fdlc, ~fd));
    settle(1'b0);
    rd(SH_STAT_OFS, 32'h00000195);
    rd(SH_DHI_OFS, fd[63:32]);
    node_b.dly = 2;
    wr(SH_STAT_OFS, 32'h00000200);
    rnd();
    node_a.send(frm(1'b0, SH, fid, fdlc, fd));
    settle(1'b0);
    exp_b.push_back(frm(1'b0, SH, fid, fdlc, fd));
    wr(SH_STAT_OFS, 32'h00000100);
    settle(1'b0);
    wr(SH_STAT_OFS, 32'h00000155);
    wr(SH_CFG_OFS, 32'h00010065);
    for (int i = 0; i < 2; i++) begin
      rnd();
      node_a.send(frm(1'b0, SH, fid, fdlc, fd));
      exp_b.push_back(frm(1'b0, SH, fid, fdlc, fd));
      settle(1'b0);
      node_b.send(frm(1'b1, SH, fid, fdlc, 64'h0));
      exp_a.push_back(frm(1'b1, SH, fid, fdlc, 64'h0));
      settle(1'b0);
      rd(SH_STAT_OFS, 32'h00000155);
    end
    rd(SH_CFG_OFS, 32'h00010065);
    wr(SH_CFG_OFS, 32'h00010005);
    rnd();
    node_a.send(frm(1'b0, SH, fid, fdlc, fd));
    settle(1'b0);
    node_b.send(frm(1'b1, SH, fid, fdlc, 64'h0));
    exp_b.push_back(frm(1'b0, SH, fid, fdlc, fd));
    settle(1'b0);
    wr(SH_STAT_OFS, 32'h00000002);
    exp_a.push_back(frm(1'b1, SH, fid, fdlc, 64'h0));
    settle(1'b0);
    // Select bit set: B is source, frames on A ignored
    wr(SH_CFG_OFS, 32'h0001002D);
    rnd();
    node_a.send(frm(1'b0, SH, ~fid, fdlc, ~fd));
    node_b.send(frm(1'b0, SH, fid, fdlc, fd));
    exp_a.push_back(frm(1'b0, SH, fid, fdlc, fd));
    settle(1'b0);
    rd(SH_CFG_OFS, 32'h0001002D);
    wr(SH_CFG_OFS, 32'h00000000);
    wr(FIFO_CFG_OFS, 32'h00000202);
    wr(GW_CFG_OFS, 32'h03080024);
    for (int i = 0; i < 5; i++) begin
      rnd();
      node_a.send(frm(1'b0, SRC, fid, fdlc, fd));
      exp_b.push_back(frm(1'b0, 5'h08 | 5'(i % 4), 29'h0, 4'h0, fd));
      settle(1'b1);
    end
    // Fifth copy wrapped onto the base element
    wr(FIFO_SEL_OFS, 32'h00000000);
    rd(FIFO_DLO_OFS, fd[31:0]);
    rd(FIFO_DHI_OFS, fd[63:32]);
    rd(GW_CFG_OFS, 32'h03090024);
    wr(GW_CFG_OFS, 32'h03090004);
    rnd();
    node_a.send(frm(1'b0, SRC, fid, fdlc, fd));
    settle(1'b1);
    node_b.send(frm(1'b1, 5'h09, 29'h0, 4'h0, 64'h0));
    exp_b.push_back(frm(1'b0, 5'h09, 29'h0, 4'h0, fd));
    settle(1'b1);
    rd(GW_CFG_OFS, 32'h030A0004);
    // Buffer lock holds a remote answer until released
    wr(FIFO_CFG_OFS, 32'h00000402);
    node_b.send(frm(1'b1, 5'h09, 29'h0, 4'h0, 64'h0));
    settle(1'b1);
    exp_b.push_back(frm(1'b0, 5'h09, 29'h0, 4'h0, fd));
    wr(FIFO_CFG_OFS, 32'h00000202);
    settle(1'b1);
    conclude();
  end
endmodule // can_gateway_fifo_and_shared_tb_top
